/* hdl/ustr_core.sv */
// async serial transceiver: wishbone registers, transmitter, receiver
// assumes serial_in_pin is asynchronous; one clock clk_i at 100 MHz
//
// Register access over Wishbone and the address map were decided locally.
`timescale 1ns/1ps
// Functional notes
// - finished character moves from receive shifter to 8-bit receive buffer
// - 7-bit receive: lsb-first bits 6..0, msb-first bits 7..1, spare bit zero
// - on overrun the new character is dropped, buffer keeps old data
// - receive buffer is all ones at reset and while power is off
// - holding write with power and tx enable starts a transmission unless one is still queued
// - tx-enable request raised when holding moves to shifter, then shifting begins
// - 7-bit transmit takes bits 6..0 lsb-first, bits 7..1 msb-first
// - holding register is read/write, resets to all ones
// - holding write while disabled never starts a transmission later
// - receive-complete request ranks above tx-enable request
// - receive errors also raise receive-complete request
// - no receive-complete request while reception disabled
// - frame: start, 7/8 data, even/odd/zero/no parity, 1/2 stops, either order
// - separate inversion options for transmit and receive lines
// - transmitter adds start, parity and stop bits itself
// - start accepted only if line still low half a bit after falling edge
// - stop bit received: request raised and buffer loaded together
// - parity/framing errors still load buffer; request at the stop bit with the load
// - receiver checks only the first stop bit
// - error flags stay set, clear on write of 0 or on rx/power disable, ignore write of 1
// - even parity makes count of ones even; odd count flags an error
module ustr_core #(
  parameter int DIV_W = 16
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        serial_in_pin_i,
  output logic             serial_out_pin_o,
  output logic             rx_complete_irq_o,
  output logic             tx_enable_irq_o,
  output logic             irq_o,
  output logic             irq_is_rx_o
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_START = 3'b001, ST_DATA = 3'b011,
    ST_PAR  = 3'b010, ST_STOP  = 3'b110, ST_STOP2 = 3'b111
  } ustr_state_e;

  typedef struct packed {
    logic [31:0]      dat;
    logic             ack;
    logic [7:0]       fmt;
    logic [1:0]       opt;
    logic [DIV_W-1:0] baud;
    logic [7:0]       rxbuf;
    logic             rx_unread;
    logic [7:0]       txhold;
    logic             tx_pend;
    logic [2:0]       err;       // pe, fe, ove
    logic             tsf;
    logic             rif;
    logic             tif;
    ustr_state_e      ts;
    logic [3:0]       tph;
    logic [2:0]       tcnt;
    logic [7:0]       tsh;
    logic             tpar;
    logic             txd;
    logic             irq;
    logic             irq_rx;
    ustr_state_e      rs;
    logic [3:0]       rph;
    logic [2:0]       rcnt;
    logic [7:0]       rsh;
    logic             rpar;
    logic             rprev;
    logic [1:0]       sync;
  } ustr_core_s;
  ustr_core_s st, next_st;

  logic tick;
  logic pwr, txe, rxe, len8, lsb;
  logic [1:0] pmode;
  logic rxd;

  // ==========================================================
  // control decode
  assign pwr   = st.fmt[ustr_pkg::FMT_PWR];
  assign txe   = st.fmt[ustr_pkg::FMT_TXE];
  assign rxe   = st.fmt[ustr_pkg::FMT_RXE];
  assign len8  = st.fmt[ustr_pkg::FMT_CL];
  assign lsb   = st.fmt[ustr_pkg::FMT_DIR];
  assign pmode = {st.fmt[ustr_pkg::FMT_PS1], st.fmt[ustr_pkg::FMT_PS0]};
  // second sync stage, then optional inversion
  assign rxd   = st.sync[1] ^ st.opt[ustr_pkg::OPT_RDL];

  ustr_tick #(.W(DIV_W)) u_tick (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .run_i  (pwr),
    .div_i  (st.baud),
    .tick_o (tick)
  );

  // parity bit to send or expect for a character
  function automatic logic par_bit(input logic [7:0] d, input logic [1:0] m);
    par_bit = (m == ustr_pkg::PAR_ODD) ? ~(^d) : (m == ustr_pkg::PAR_EVEN) ? ^d : 1'b0;
  endfunction

  logic wr, rd;
  assign wr = cyc_i && stb_i && we_i && !st.ack && sel_i[0];
  assign rd = cyc_i && stb_i && !we_i && !st.ack;

  // ==========================================================
  // whole block next state
  always_comb begin
    logic [7:0] tload;
    logic [7:0] rdata;
    logic       done;
    tload   = 8'h00;
    rdata   = 8'h00;
    done    = 1'b0;
    next_st = st;
    next_st.ack = cyc_i && stb_i && !st.ack;
    next_st.rif = 1'b0;
    next_st.tif = 1'b0;
    next_st.sync = {st.sync[0], serial_in_pin_i};
    // read mux; unmapped offsets read zero
    case (adr_i)
      ustr_pkg::ADDR_RXBUF:  next_st.dat = {24'h0, st.rxbuf};
      ustr_pkg::ADDR_TXHOLD: next_st.dat = {24'h0, st.txhold};
      ustr_pkg::ADDR_FORMAT: next_st.dat = {24'h0, st.fmt};
      ustr_pkg::ADDR_OPTION: next_st.dat = {30'h0, st.opt};
      ustr_pkg::ADDR_STATUS: next_st.dat = {24'h0, st.tsf, 4'h0, st.err};
      ustr_pkg::ADDR_BAUD:   next_st.dat = {{(32-DIV_W){1'b0}}, st.baud};
      ustr_pkg::ADDR_IRQ:    next_st.dat = {30'h0, st.tif, st.rif};
      default:               next_st.dat = 32'h0;
    endcase
    if (rd && adr_i == ustr_pkg::ADDR_RXBUF) begin
      next_st.rx_unread = 1'b0;
    end
    // register writes need byte lane 0; baud takes DIV_W bits
    if (wr) begin
      case (adr_i)
        ustr_pkg::ADDR_TXHOLD: begin
          next_st.txhold  = dat_i[7:0];
          next_st.tx_pend = pwr && txe;
        end
        ustr_pkg::ADDR_FORMAT: next_st.fmt  = dat_i[7:0];
        ustr_pkg::ADDR_OPTION: next_st.opt  = dat_i[1:0];
        ustr_pkg::ADDR_BAUD:   next_st.baud = dat_i[DIV_W-1:0];
        ustr_pkg::ADDR_STATUS: next_st.err  = st.err & dat_i[2:0];
        default: ;
      endcase
    end

    // transmitter: load shifter on tick when idle
    if (tick) begin
      case (st.ts)
        ST_IDLE: if (st.tx_pend) begin
          tload = len8 ? st.txhold : (lsb ? {1'b0, st.txhold[6:0]} : {st.txhold[7:1], 1'b0});
          next_st.tsh = lsb ? tload : (len8 ? tload : {1'b0, tload[7:1]});
          next_st.tpar = par_bit(tload, pmode);
          // a holding write landing in the load cycle stays queued: set wins
          next_st.tx_pend = wr && (adr_i == ustr_pkg::ADDR_TXHOLD) && pwr && txe;
          next_st.tif = 1'b1;
          next_st.tsf = 1'b1;
          next_st.ts = ST_START;
          next_st.tph = 4'h0;
          next_st.txd = 1'b0;                            // start bit
        end
        default: begin
          next_st.tph = st.tph + 4'h1;
          if (st.tph == ustr_pkg::BAUD_OVS) begin
            case (st.ts)
              ST_START: begin
                next_st.ts = ST_DATA;
                next_st.tcnt = 3'h0;
                next_st.txd = lsb ? st.tsh[0] : (len8 ? st.tsh[7] : st.tsh[6]);
              end
              ST_DATA: begin
                next_st.tsh = lsb ? {1'b0, st.tsh[7:1]} : {st.tsh[6:0], 1'b0};
                next_st.tcnt = st.tcnt + 3'h1;
                if (st.tcnt == (len8 ? 3'h7 : 3'h6)) begin
                  next_st.ts = (pmode == ustr_pkg::PAR_NONE) ? ST_STOP : ST_PAR;
                  next_st.txd = (pmode == ustr_pkg::PAR_NONE) ? 1'b1 : st.tpar;
                end else begin
                  next_st.txd = lsb ? st.tsh[1] : (len8 ? st.tsh[6] : st.tsh[5]);
                end
              end
              ST_PAR: begin
                next_st.ts = ST_STOP;
                next_st.txd = 1'b1;
              end
              ST_STOP: begin
                next_st.ts = st.fmt[ustr_pkg::FMT_SL] ? ST_STOP2 : ST_IDLE;
                next_st.tsf = st.fmt[ustr_pkg::FMT_SL] || st.tx_pend;
              end
              default: begin
                next_st.ts = ST_IDLE;
                next_st.tsf = st.tx_pend;
              end
            endcase
          end
        end
      endcase
    end

    // receiver; 16 ticks per bit, sample at phase 8
    if (tick) begin
      next_st.rprev = rxd;
      case (st.rs)
        ST_IDLE: if (st.rprev && !rxd) begin
          next_st.rs = ST_START;
          next_st.rph = 4'h1;
        end
        default: begin
          next_st.rph = st.rph + 4'h1;
          if (st.rph == 4'h8) begin
            case (st.rs)
              ST_START: begin
                // glitch filter: still low at half bit
                next_st.rs = rxd ? ST_IDLE : ST_DATA;
                next_st.rcnt = 3'h0;
                next_st.rsh = 8'h00;
              end
              ST_DATA: begin
                next_st.rsh = lsb ? {rxd, st.rsh[7:1]} : {st.rsh[6:0], rxd};
                next_st.rcnt = st.rcnt + 3'h1;
                if (st.rcnt == (len8 ? 3'h7 : 3'h6)) begin
                  next_st.rs = (pmode == ustr_pkg::PAR_NONE) ? ST_STOP : ST_PAR;
                end
              end
              ST_PAR: begin
                next_st.rpar = rxd;
                next_st.rs = ST_STOP;
              end
              default: begin
                // only first stop bit checked, second ignored
                done = 1'b1;
                next_st.rs = ST_IDLE;
              end
            endcase
          end
        end
      endcase
    end
    // align 7-bit data: lsb-first in 6..0, msb-first in 7..1
    rdata = len8 ? st.rsh : (lsb ? {1'b0, st.rsh[7:1]} : {st.rsh[6:0], 1'b0});
    if (done && rxe && pwr) begin
      if (st.rx_unread && !(rd && adr_i == ustr_pkg::ADDR_RXBUF)) begin
        next_st.err[0] = 1'b1;                       // overrun, drop data
      end else begin
        next_st.rxbuf = rdata;
        next_st.rx_unread = 1'b1;
      end
      if (!rxd) begin
        next_st.err[1] = 1'b1;                       // framing
      end
      if ((pmode[1]) && (par_bit(rdata, pmode) != st.rpar)) begin
        next_st.err[2] = 1'b1;                       // parity
      end
      next_st.rif = 1'b1;
    end

    // disable clears per status table; power off restores buffer
    if (!pwr || !txe) begin
      next_st.ts = ST_IDLE;
      next_st.tsf = 1'b0;
      next_st.tx_pend = 1'b0;
      next_st.tif = 1'b0;                            // nothing moved to shifter
      next_st.txd = 1'b1;
    end
    if (!pwr || !rxe) begin
      next_st.rs = ST_IDLE;
      next_st.err = 3'h0;
      next_st.rif = 1'b0;
    end
    if (!pwr) begin
      next_st.rxbuf = ustr_pkg::RST_BUF;
      next_st.rx_unread = 1'b0;
    end
    // fixed priority: receive first
    next_st.irq = next_st.rif || next_st.tif;
    next_st.irq_rx = next_st.rif;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.fmt <= ustr_pkg::RST_FORMAT;
      st.baud <= DIV_W'(ustr_pkg::RST_BAUD);
      st.rxbuf <= ustr_pkg::RST_BUF;
      st.txhold <= ustr_pkg::RST_BUF;
      st.txd <= 1'b1;
      st.rprev <= 1'b1;
      st.sync <= 2'b11;
      st.ts <= ST_IDLE;
      st.rs <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ==========================================================
  // outputs, inversion applied as pin level
  logic txo;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      txo <= 1'b1;
    end else begin
      txo <= next_st.txd ^ st.opt[ustr_pkg::OPT_TDL];
    end
  end
  assign serial_out_pin_o  = txo;
  assign dat_o             = st.dat;
  assign ack_o             = st.ack;
  assign rx_complete_irq_o = st.rif;
  assign tx_enable_irq_o   = st.tif;
  assign irq_o             = st.irq;
  assign irq_is_rx_o       = st.irq_rx;

  // ==========================================================
  // assertions
  a_rx_disabled_quiet: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(rxe) |-> !rx_complete_irq_o) else $error("rx irq while rx disabled");
  a_power_off_buf: assert property (@(posedge clk_i) disable iff (rst_i)
    !$past(pwr) |-> st.rxbuf == 8'hFF) else $error("buffer not all ones");
  a_prio_rx_first: assert property (@(posedge clk_i) disable iff (rst_i)
    rx_complete_irq_o |-> irq_is_rx_o) else $error("priority wrong");
  a_tx_start_low: assert property (@(posedge clk_i) disable iff (rst_i)
    tx_enable_irq_o |-> st.ts == ST_START && st.txd == 1'b0) else $error("no start bit");
  a_disabled_write: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr && adr_i == ustr_pkg::ADDR_TXHOLD && !(pwr && txe)) |=> !st.tx_pend)
    else $error("disabled write queued");
  a_err_sticky: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.err[0] && pwr && rxe && !(wr && adr_i == ustr_pkg::ADDR_STATUS)) |=> st.err[0])
    else $error("overrun flag lost");
  a_overrun_keep: assert property (@(posedge clk_i) disable iff (rst_i)
    ($rose(st.err[0]) && $past(pwr)) |-> $stable(st.rxbuf)) else $error("overrun wrote buffer");
  a_idle_high: assert property (@(posedge clk_i) disable iff (rst_i)
    (st.ts == ST_IDLE && $past(st.ts) == ST_IDLE && $stable(st.opt))
      |-> serial_out_pin_o == ~st.opt[ustr_pkg::OPT_TDL]) else $error("idle line level");
  a_ack_one: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o |=> !ack_o) else $error("ack held");
  c_tx_start: cover property (@(posedge clk_i) tx_enable_irq_o);
  c_rx_done: cover property (@(posedge clk_i) rx_complete_irq_o);
  c_overrun: cover property (@(posedge clk_i) $rose(st.err[0]));
endmodule // ustr_core

/* hdl/ustr_pkg.sv */
// package of constants for the async serial transceiver core
// assumes a wishbone classic slave with 32-bit data and byte addressing
package ustr_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [4:0] ADDR_RXBUF  = 5'h00; // receive_buffer
  localparam logic [4:0] ADDR_TXHOLD = 5'h04; // transmit_holding
  localparam logic [4:0] ADDR_FORMAT = 5'h08; // format_control_reg
  localparam logic [4:0] ADDR_OPTION = 5'h0C; // option_control_reg
  localparam logic [4:0] ADDR_STATUS = 5'h10; // line_status_reg
  localparam logic [4:0] ADDR_BAUD   = 5'h14; // baud_divider_reg
  localparam logic [4:0] ADDR_IRQ    = 5'h18; // request flags
  // ==========================================================
  // format_control_reg fields
  localparam int FMT_PWR = 7;
  localparam int FMT_TXE = 6;
  localparam int FMT_RXE = 5;
  localparam int FMT_PS1 = 4;
  localparam int FMT_PS0 = 3;
  localparam int FMT_CL  = 2; // 1: 8-bit chars
  localparam int FMT_SL  = 1; // 1: two stop bits
  localparam int FMT_DIR = 0; // 1: lsb first
  // option_control_reg fields
  localparam int OPT_TDL = 1;
  localparam int OPT_RDL = 0;
  // line_status_reg fields
  localparam int STS_TSF = 7;
  localparam int STS_PE  = 2;
  localparam int STS_FE  = 1;
  localparam int STS_OVE = 0;
  // parity modes {ps1,ps0}
  localparam logic [1:0] PAR_NONE = 2'h0;
  localparam logic [1:0] PAR_ZERO = 2'h1;
  localparam logic [1:0] PAR_ODD  = 2'h2;
  localparam logic [1:0] PAR_EVEN = 2'h3;
  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_BUF    = 8'hFF;
  localparam logic [7:0]  RST_FORMAT = 8'h05;
  localparam logic [15:0] RST_BAUD   = 16'h0363; // 867: 55-clock ticks, 880-clock bit, about 113600 baud at 100 MHz
  localparam logic [3:0]  BAUD_OVS   = 4'hF;     // 16 ticks per bit
endpackage

/* hdl/ustr_tick.sv */
// oversampling tick generator for the serial core
// assumes a divider value written by software; zero is treated as one
`timescale 1ns/1ps
module ustr_tick #(
  parameter int W = 16
) (
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  input  wire logic         run_i,
  input  wire logic [W-1:0] div_i,
  output logic              tick_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         tick;
  } ustr_tick_s;
  ustr_tick_s st, next_st;

  // ==========================================================
  // count down, pulse at zero
  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run_i) begin
      next_st.cnt = '0;
    end else if (st.cnt == '0) begin
      next_st.cnt  = (div_i > W'(4)) ? W'(div_i / W'(16)) : W'(0);
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt - W'(1);
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
  assign tick_o = st.tick;
endmodule // ustr_tick

/* test/async_serial_tx_rx_core_tb.sv */
// testbench for the serial core: wishbone tasks, node model on the lines
// assumes baud register 0x10 gives two-clock ticks, so one bit is 32 clocks
`timescale 1ns/1ps
module async_serial_tx_rx_core_tb;
  localparam int BIT = 32;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i  = 1'b0;
  logic [4:0]  adr_i = 5'h00;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0;
  logic [31:0] dat_o, rd;
  logic        ack_o, so, rxl, rxc, txc, irq, irq_rx;
  logic [11:0] f, g0, g1;
  logic [4:0]  cf [4] = '{5'h1D, 5'h0A, 5'h11, 5'h04};
  logic [7:0]  dv [4] = '{8'hB4, 8'h6D, 8'h39, 8'hC2};
  logic        inv;
  int          fails = 0, n_checks = 0, n_rx = 0, n_tx = 0, cyc_n = 0;
  int          n, t, r, w;

  always #5 clk_i = ~clk_i;

  ustr_core u_ustr_core (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .serial_in_pin_i(rxl), .serial_out_pin_o(so),
    .rx_complete_irq_o(rxc), .tx_enable_irq_o(txc), .irq_o(irq), .irq_is_rx_o(irq_rx));
  ustr_node #(.BIT(BIT)) u_ustr_node (.clk_i(clk_i), .line_i(so), .line_o(rxl));

  // ==========================================================
  // compare and report
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // pulse counters and hang guard; rx pulses must rank first
  always @(posedge clk_i) begin
    if (rxc === 1'b1) begin
      n_rx <= n_rx + 1;
      chk("irq_rank", {30'h0, irq, irq_rx}, 32'h3);
    end
    if (txc === 1'b1) n_tx <= n_tx + 1;
    cyc_n <= cyc_n + 1;
    if (cyc_n == 60000) begin
      fails++;
      test_done();
    end
  end

  // ==========================================================
  // one classic cycle; entered just after a rising edge
  task automatic wb(input logic wr_en, input logic [4:0] a, input logic [31:0] d);
    int k;
    k = 0;
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr_en;
    adr_i <= a;
    dat_i <= d;
    sel_i <= 4'hF;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack_o !== 1'b1 && k < 100);
    if (k >= 100) fails++;
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [4:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask

  // expected frame: start, data in wire order, parity, stops (bit 0 first)
  function automatic logic [11:0] mk(input logic [7:0] d, input logic [4:0] c,
                                     output int nb);
    logic [7:0]  s;
    logic [11:0] fr;
    logic        p;
    int          nd;
    nd = c[2] ? 8 : 7;
    for (int i = 0; i < 8; i++) s[i] = c[0] ? d[i] : d[7-i];
    fr = 12'hFFF;
    fr[0] = 1'b0;
    for (int i = 0; i < nd; i++) fr[i+1] = s[i];
    nb = nd + 1;
    p = ^(s & (c[2] ? 8'hFF : 8'h7F));
    if (c[4:3] != ustr_pkg::PAR_NONE) begin
      fr[nb] = (c[4:3] == ustr_pkg::PAR_EVEN) ? p : (c[4:3] == ustr_pkg::PAR_ODD) ? ~p : 1'b0;
      nb++;
    end
    nb = nb + 1 + int'(c[1]);
    return fr;
  endfunction

  // ==========================================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc("rxbuf_rst", ustr_pkg::ADDR_RXBUF, 32'h000000FF);
    rdc("txhold_rst", ustr_pkg::ADDR_TXHOLD, 32'h000000FF);
    rdc("unmapped", 5'h1C, 32'h0);
    wr(ustr_pkg::ADDR_BAUD, 32'h00000010);
    wr(ustr_pkg::ADDR_TXHOLD, 32'h0000003C);
    rdc("txhold_rw", ustr_pkg::ADDR_TXHOLD, 32'h0000003C);
    wr(ustr_pkg::ADDR_FORMAT, 32'h000000C5);
    u_ustr_node.grab(1, 1'b0, g0);
    chk("no_tx", {g0, 12'(n_tx)}, {12'hFFF, 12'h000});
    $display("test registers and disabled write done");
    // every parity mode, both lengths, stops and orders; third one inverted
    for (int i = 0; i < 4; i++) begin
      inv = (i == 2);
      wr(ustr_pkg::ADDR_FORMAT, {27'h0, cf[i]}); // unit off first
      u_ustr_node.idle(inv); // mark level before power-up, else a false start
      wr(ustr_pkg::ADDR_OPTION, {30'h0, inv, inv});
      wr(ustr_pkg::ADDR_FORMAT, {24'h0, 3'h7, cf[i]});
      chk("idle", {31'h0, so}, {31'h0, ~inv});
      t = n_tx;
      f = mk(dv[i], cf[i], n);
      fork
        begin
          u_ustr_node.grab(n, inv, g0);
          u_ustr_node.grab(n, inv, g1);
        end
        begin
          wr(ustr_pkg::ADDR_TXHOLD, {24'h0, dv[i]});
          w = 0;
          while (n_tx == t && w < 3000) begin
            @(posedge clk_i);
            w++;
          end
          wr(ustr_pkg::ADDR_TXHOLD, {24'h0, dv[i]}); // same value after request
        end
      join
      chk("tx_frame0", g0, f);
      chk("tx_frame1", g1, f);
      chk("tx_irqs", n_tx - t, 2);
      r = n_rx;
      u_ustr_node.send(f, n, inv);
      chk("rx_irq", n_rx - r, 1);
      rdc("rxbuf", ustr_pkg::ADDR_RXBUF, {24'h0, cf[i][2] ? dv[i] :
          cf[i][0] ? {1'b0, dv[i][6:0]} : {dv[i][7:1], 1'b0}});
      rdc("status", ustr_pkg::ADDR_STATUS, 32'h0);
    end
    $display("test frame formats done");
    // parity and framing error together, still loaded
    wr(ustr_pkg::ADDR_FORMAT, 32'h0000001D);
    wr(ustr_pkg::ADDR_FORMAT, 32'h000000FD);
    r = n_rx;
    f = mk(8'h5A, 5'h1D, n);
    u_ustr_node.send(f ^ 12'h600, n, 1'b0);
    chk("err_irq", n_rx - r, 1);
    rdc("err_buf", ustr_pkg::ADDR_RXBUF, 32'h0000005A);
    rdc("err_flags", ustr_pkg::ADDR_STATUS, 32'h00000006);
    wr(ustr_pkg::ADDR_STATUS, 32'h000000FF);
    rdc("flags_keep", ustr_pkg::ADDR_STATUS, 32'h00000006);
    wr(ustr_pkg::ADDR_STATUS, 32'h0);
    rdc("flags_clr", ustr_pkg::ADDR_STATUS, 32'h0);
    $display("test reception errors done");
    // second character while first is unread
    u_ustr_node.send(mk(8'h11, 5'h1D, n), n, 1'b0);
    u_ustr_node.send(mk(8'h22, 5'h1D, n), n, 1'b0);
    rdc("ovr_buf", ustr_pkg::ADDR_RXBUF, 32'h00000011);
    rdc("ovr_flag", ustr_pkg::ADDR_STATUS, 32'h00000001);
    wr(ustr_pkg::ADDR_STATUS, 32'h0);
    $display("test overrun done");
    // short low pulse is no start bit
    r = n_rx;
    u_ustr_node.glitch(BIT / 4);
    repeat (12 * BIT) @(posedge clk_i);
    chk("glitch", n_rx - r, 0);
    // reception disabled: no request
    wr(ustr_pkg::ADDR_FORMAT, 32'h000000DD);
    u_ustr_node.send(mk(8'h33, 5'h1D, n), n, 1'b0);
    chk("rx_off", n_rx - r, 0);
    wr(ustr_pkg::ADDR_FORMAT, 32'h0000001D);
    rdc("pwr_off", ustr_pkg::ADDR_RXBUF, 32'h000000FF);
    $display("test start filter and disable done");
    test_done();
  end
endmodule // async_serial_tx_rx_core_tb

/* test/ustr_node.sv */
// remote serial node model: drives the receive line, captures the transmit line
// assumes one shared clock and a bit period given in clk_i cycles
`timescale 1ns/1ps
module ustr_node #(
  parameter int BIT = 32
) (
  input  wire logic clk_i,
  input  wire logic line_i,
  output logic      line_o
);
  initial line_o = 1'b1;

  // ==========================================================
  // send one frame, bit 0 of f first, then back to mark level
  task automatic send(input logic [11:0] f, input int n, input logic inv);
    for (int i = 0; i < n * BIT; i++) begin
      @(posedge clk_i);
      line_o <= f[i / BIT] ^ inv;
    end
    @(posedge clk_i);
    line_o <= ~inv;
  endtask

  // park the line at mark level for the given polarity; called after an edge
  task automatic idle(input logic inv);
    line_o <= ~inv;
  endtask

  // short low pulse, too brief to count as a start bit
  task automatic glitch(input int len);
    repeat (len) @(posedge clk_i) line_o <= 1'b0;
    @(posedge clk_i);
    line_o <= 1'b1;
  endtask

  // ==========================================================
  // capture n bits at mid-bit; stays all ones when no start comes
  // returns at mid of the last bit so a back-to-back start is not missed
  task automatic grab(input int n, input logic inv, output logic [11:0] f);
    int w;
    f = 12'hFFF;
    w = 0;
    while ((line_i ^ inv) !== 1'b0 && w < 4000) begin
      @(posedge clk_i);
      w++;
    end
    if (w < 4000) begin
      repeat (BIT / 2) @(posedge clk_i);
      for (int i = 0; i < n; i++) begin
        f[i] = line_i ^ inv;
        if (i < n - 1) repeat (BIT) @(posedge clk_i);
      end
    end
  endtask
endmodule // ustr_node
